// ==== hw/nts_tag_fsm.sv ====
// nfc-a tag protocol state machine with kill, lockout and access control
//
// Summary of operation
// RULE1: full kill: ignore rf, never answer
// RULE2: host kill: refuse tunnel and extended modes
// RULE3: kill config changes only from microcontroller port
// RULE4: run whole anti-collision with 7-byte uid
// RULE5: reject access beyond implemented memory
// RULE6: start in sense; leave on sens/all
// RULE7: other frames in sense: error, stay
// RULE8: slp_req in selected/auth: sleep becomes waiting
// RULE9: sleep left only by all_req (code also leaves it on the mcu sense command)
// RULE10: resolution runs cascade levels one, two
// RULE11: invalid command in selected: fall back
// RULE12: sector select: nak, then fall back
// RULE13: password write match enters authenticated
// RULE14: seven failed passwords enter locked
// RULE15: mcu clears counter, then sense command
// RULE16: locked: access only below protection limit
// RULE17: authenticated: protected blocks fully accessible
// RULE18: memory access by read/write, selected only
// RULE19: first three uid bytes hardwired inputs
// RULE20: byte zero maker, byte one type
// RULE21: uid byte two is 02h
// RULE22: uid bytes three-six from uid word
// RULE23: uid word writes always refused
// RULE24: one bit records sense or sleep waiting
`timescale 1ns/1ns
`default_nettype none

module nts_tag_fsm
  import nts_pkg::*;
#(
  parameter logic [7:0] MAKER_CODE = 8'hA5,  // arbitrary value
  parameter logic [7:0] TYPE_CODE  = 8'h5A,  // arbitrary value
  parameter logic [7:0] MEM_TOP    = 8'h3F,  // last implemented block
  parameter logic [7:0] PWD_ADDR   = 8'h3E,  // password block
  parameter logic [7:0] UID_ADDR   = 8'h00   // uid block
) (
  // clock and reset
  input  wire logic              clk_i,
  input  wire logic              rst_b_i,
  // rf command from the frame decoder
  input  wire logic              cmd_valid_i,
  input  wire logic [3:0]        cmd_code_i,
  input  wire logic [ADDR_W-1:0] cmd_addr_i,
  input  wire logic              cmd_sel_ok_i,   // sel_req matched our uid part
  input  wire logic              cmd_pwd_ok_i,   // written word equals password
  input  wire logic              cmd_tunnel_i,   // request for tunnel/extended
  // microcontroller side
  input  wire logic              mcu_kill_we_i,
  input  wire logic [1:0]        mcu_kill_i,
  input  wire logic              mcu_cnt_clr_i,
  input  wire logic              mcu_goto_sense_i,
  input  wire logic              rf_kill_we_i,   // kill write seen on rf
  input  wire logic [7:0]        prot_limit_i,   // protected_area_limit
  input  wire logic [31:0]       uid_word_i,
  // responses
  output logic                   rsp_valid_o,
  output logic [2:0]             rsp_kind_o,
  output logic [31:0]            rsp_uid_o,
  output logic                   mem_rd_o,
  output logic                   mem_wr_o,
  output logic [ADDR_W-1:0]      mem_addr_o,
  output logic                   tunnel_en_o,
  output logic [2:0]             state_o,
  output logic                   locked_o,
  output logic [2:0]             fail_cnt_o
);

  // ****************************************
  // state
  // ****************************************
  nts_state_t state;
  nts_state_t next_state;
  logic       wait_sleep;          // waiting state is sleep
  logic [1:0] kill_cfg;
  logic [2:0] failed_auth_counter;
  logic       locked;
  nts_cmd_t   cmd;
  logic       live;
  logic       in_sel;
  logic       addr_ok;
  logic       pwd_try;
  nts_rsp_t   next_rsp;
  nts_state_t fall_state;
  logic       goto_ok;             // microcontroller return is allowed

  function automatic logic [31:0] uid_chunk(input logic lvl2, input logic [31:0] w);
    // cascade 1: ct, byte0, byte1, byte2; cascade 2: bytes 3..6
    uid_chunk = lvl2 ? w                                               // [RULE22]
      : {UID_BYTE2, TYPE_CODE, MAKER_CODE, CASCADE_TAG};               // [RULE19] [RULE20] [RULE21]
  endfunction

  assign cmd        = nts_cmd_t'(cmd_code_i);
  assign live       = cmd_valid_i && (kill_cfg != KILL_RF);                    // [RULE1]
  assign in_sel     = (state == NTS_SELECT) || (state == NTS_AUTH);
  assign fall_state = wait_sleep ? NTS_SLEEP : NTS_SENSE;                      // [RULE24]
  assign pwd_try    = (cmd == NTS_CMD_WRITE) && (cmd_addr_i == PWD_ADDR);
  assign goto_ok    = mcu_goto_sense_i &&
                      (!locked || (failed_auth_counter == AUTH_FAIL_ZERO));    // [RULE15]

  // address check: range, uid write, lockout and protection
  always_comb begin
    addr_ok = (cmd_addr_i <= MEM_TOP);                                         // [RULE5]
    if ((cmd == NTS_CMD_WRITE) && (cmd_addr_i == UID_ADDR)) begin
      addr_ok = 1'b0;                                                          // [RULE23]
    end
    if (locked && (cmd_addr_i >= prot_limit_i)) begin
      addr_ok = 1'b0;                                                          // [RULE16]
    end
    if ((state == NTS_SELECT) && !locked && (cmd_addr_i >= prot_limit_i)) begin
      addr_ok = 1'b0;                                                          // protected until auth
    end
    if ((state == NTS_AUTH) && !locked) begin
      addr_ok = (cmd_addr_i <= MEM_TOP) &&
                !((cmd == NTS_CMD_WRITE) && (cmd_addr_i == UID_ADDR));         // [RULE17]
    end
  end

  // next state and response
  always_comb begin
    next_state = state;
    next_rsp   = NTS_RSP_NONE;
    if (live) begin
      unique case (state)
        NTS_SENSE: begin
          if ((cmd == NTS_CMD_SENS) || (cmd == NTS_CMD_ALL)) begin             // [RULE6] [RULE7]
            next_state = NTS_RES1;
            next_rsp   = NTS_RSP_SENS;
          end
        end
        NTS_SLEEP: begin
          if (cmd == NTS_CMD_ALL) begin                                        // [RULE9]
            next_state = NTS_RES1;
            next_rsp   = NTS_RSP_SENS;
          end
        end
        NTS_RES1, NTS_RES2: begin                                              // [RULE4] [RULE10]
          if (cmd == NTS_CMD_SDD) begin
            next_rsp = NTS_RSP_UID;
          end else if ((cmd == NTS_CMD_SEL) && cmd_sel_ok_i) begin
            next_state = (state == NTS_RES1) ? NTS_RES2 : NTS_SELECT;
            next_rsp   = NTS_RSP_SAK;
          end else begin
            next_state = fall_state;
          end
        end
        NTS_SELECT, NTS_AUTH: begin
          if (cmd == NTS_CMD_SLP) begin
            next_state = NTS_SLEEP;                                            // [RULE8]
          end else if (cmd == NTS_CMD_SECSEL) begin
            next_state = fall_state;                                           // [RULE12]
            next_rsp   = NTS_RSP_NAK;
          end else if (pwd_try && !locked) begin
            if (cmd_pwd_ok_i) begin
              next_state = NTS_AUTH;                                           // [RULE13]
              next_rsp   = NTS_RSP_ACK;
            end else begin
              next_rsp   = NTS_RSP_NAK;
            end
          end else if (((cmd == NTS_CMD_READ) || (cmd == NTS_CMD_WRITE)) && addr_ok) begin
            next_rsp = (cmd == NTS_CMD_READ) ? NTS_RSP_DATA : NTS_RSP_ACK;     // [RULE18]
          end else if ((cmd == NTS_CMD_READ) || (cmd == NTS_CMD_WRITE)) begin
            next_rsp = NTS_RSP_NAK;                                            // [RULE5]
          end else begin
            next_state = fall_state;                                           // [RULE11]
          end
        end
        default: next_state = NTS_SENSE;
      endcase
    end
    if (goto_ok) begin
      next_state = NTS_SENSE;
    end
  end

  // ****************************************
  // registers
  // ****************************************

  // protocol state
  always_ff @(posedge clk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      state <= NTS_SENSE;                                                      // [RULE6]
    end else begin
      state <= next_state;
    end
  end

  // waiting state record
  always_ff @(posedge clk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      wait_sleep <= 1'b0;
    end else if (goto_ok) begin
      wait_sleep <= 1'b0;
    end else if (live && in_sel && (cmd == NTS_CMD_SLP)) begin
      wait_sleep <= 1'b1;                                                      // [RULE8] [RULE24]
    end
  end

  // kill configuration, microcontroller writes only
  always_ff @(posedge clk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      kill_cfg <= KILL_NONE;
    end else if (mcu_kill_we_i) begin
      kill_cfg <= mcu_kill_i;                                                  // [RULE3]
    end
  end

  // failed authentication counter and lockout
  always_ff @(posedge clk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      failed_auth_counter <= AUTH_FAIL_ZERO;
    end else if (mcu_cnt_clr_i) begin
      failed_auth_counter <= AUTH_FAIL_ZERO;                                   // [RULE15]
    end else if (live && in_sel && pwd_try && !locked && !cmd_pwd_ok_i &&
                 (failed_auth_counter != AUTH_FAIL_LIMIT)) begin              // saturate at limit
      failed_auth_counter <= failed_auth_counter + 3'h1;                       // [RULE14]
    end
  end

  always_ff @(posedge clk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      locked <= 1'b0;
    end else if (failed_auth_counter == AUTH_FAIL_LIMIT) begin
      locked <= 1'b1;                                                          // [RULE14]
    end else if (goto_ok) begin
      locked <= 1'b0;                                                          // [RULE15]
    end
  end

  // responses and memory strobes
  always_ff @(posedge clk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      rsp_valid_o <= 1'b0;
      rsp_kind_o  <= NTS_RSP_NONE;
      rsp_uid_o   <= 32'h0;
      mem_rd_o    <= 1'b0;
      mem_wr_o    <= 1'b0;
      mem_addr_o  <= '0;
    end else begin
      rsp_valid_o <= (next_rsp != NTS_RSP_NONE);                               // [RULE1]
      rsp_kind_o  <= next_rsp;
      rsp_uid_o   <= uid_chunk(state == NTS_RES2, uid_word_i);
      mem_rd_o    <= (next_rsp == NTS_RSP_DATA);
      mem_wr_o    <= (next_rsp == NTS_RSP_ACK) && (cmd == NTS_CMD_WRITE) && !pwd_try;
      mem_addr_o  <= cmd_addr_i;
    end
  end

  // status outputs and tunnel permission
  always_ff @(posedge clk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      tunnel_en_o <= 1'b0;
      state_o     <= NTS_SENSE;
      locked_o    <= 1'b0;
      fail_cnt_o  <= AUTH_FAIL_ZERO;
    end else begin
      tunnel_en_o <= cmd_tunnel_i && (kill_cfg == KILL_NONE) && in_sel;        // [RULE2]
      state_o     <= state;
      locked_o    <= locked;
      fail_cnt_o  <= failed_auth_counter;
    end
  end

  // ****************************************
  // checks
  // ****************************************
  property p_kill_silent;
    @(posedge clk_i) disable iff (!rst_b_i)
      (kill_cfg == KILL_RF) |=> !rsp_valid_o;
  endproperty
  a_kill_silent: assert property (p_kill_silent) else $error("answer under rf kill"); // [RULE1]

  property p_host_kill;
    @(posedge clk_i) disable iff (!rst_b_i)
      (kill_cfg != KILL_NONE) |=> !tunnel_en_o;
  endproperty
  a_host_kill: assert property (p_host_kill) else $error("tunnel under kill"); // [RULE2]

  property p_rf_no_kill;
    @(posedge clk_i) disable iff (!rst_b_i)
      (rf_kill_we_i && !mcu_kill_we_i) |=> $stable(kill_cfg);
  endproperty
  a_rf_no_kill: assert property (p_rf_no_kill) else $error("rf changed kill"); // [RULE3]

  property p_sense_stay;
    @(posedge clk_i) disable iff (!rst_b_i)
      (state == NTS_SENSE && live && cmd != NTS_CMD_SENS && cmd != NTS_CMD_ALL
       && !mcu_goto_sense_i) |=> (state == NTS_SENSE);
  endproperty
  a_sense_stay: assert property (p_sense_stay) else $error("left sense wrongly"); // [RULE7]

  property p_sleep_stay;
    @(posedge clk_i) disable iff (!rst_b_i)
      (state == NTS_SLEEP && !(live && cmd == NTS_CMD_ALL) && !mcu_goto_sense_i)
      |=> (state == NTS_SLEEP);
  endproperty
  a_sleep_stay: assert property (p_sleep_stay) else $error("left sleep wrongly"); // [RULE9]

  property p_slp_sleep;
    @(posedge clk_i) disable iff (!rst_b_i)
      (live && in_sel && cmd == NTS_CMD_SLP && !mcu_goto_sense_i)
      |=> (state == NTS_SLEEP) && wait_sleep;
  endproperty
  a_slp_sleep: assert property (p_slp_sleep) else $error("slp_req not to sleep"); // [RULE8]

  property p_secsel_nak;
    @(posedge clk_i) disable iff (!rst_b_i)
      (live && in_sel && cmd == NTS_CMD_SECSEL)
      |=> rsp_valid_o && (rsp_kind_o == NTS_RSP_NAK) && !in_sel;
  endproperty
  a_secsel_nak: assert property (p_secsel_nak) else $error("sector select not nak"); // [RULE12]

  property p_lock;
    @(posedge clk_i) disable iff (!rst_b_i)
      (failed_auth_counter == AUTH_FAIL_LIMIT) |=> locked;
  endproperty
  a_lock: assert property (p_lock) else $error("no lockout at limit"); // [RULE14]

  property p_uid_safe;
    @(posedge clk_i) disable iff (!rst_b_i)
      (live && cmd == NTS_CMD_WRITE && cmd_addr_i == UID_ADDR) |=> !mem_wr_o;
  endproperty
  a_uid_safe: assert property (p_uid_safe) else $error("uid block written"); // [RULE23]

  property p_range;
    @(posedge clk_i) disable iff (!rst_b_i)
      (live && cmd_addr_i > MEM_TOP) |=> !mem_rd_o && !mem_wr_o;
  endproperty
  a_range: assert property (p_range) else $error("access out of range"); // [RULE5]

  property p_auth_enter;
    @(posedge clk_i) disable iff (!rst_b_i)
      (live && in_sel && pwd_try && !locked && cmd_pwd_ok_i && !mcu_goto_sense_i)
      |=> (state == NTS_AUTH);
  endproperty
  a_auth_enter: assert property (p_auth_enter) else $error("password match not auth"); // [RULE13]

  property p_locked_guard;
    @(posedge clk_i) disable iff (!rst_b_i)
      (live && locked && (cmd_addr_i >= prot_limit_i)) |=> !mem_rd_o && !mem_wr_o;
  endproperty
  a_locked_guard: assert property (p_locked_guard) else $error("locked guard"); // [RULE16]

  property p_mem_sel;
    @(posedge clk_i) disable iff (!rst_b_i)
      !in_sel |=> !mem_rd_o && !mem_wr_o;
  endproperty
  a_mem_sel: assert property (p_mem_sel) else $error("memory access outside selected"); // [RULE18]

  property p_count_hold;
    @(posedge clk_i) disable iff (!rst_b_i)
      (failed_auth_counter == AUTH_FAIL_LIMIT && !mcu_cnt_clr_i)
      |=> (failed_auth_counter == AUTH_FAIL_LIMIT);
  endproperty
  a_count_hold: assert property (p_count_hold) else $error("fail count left limit"); // [RULE14]

  property p_release;
    @(posedge clk_i) disable iff (!rst_b_i)
      (mcu_goto_sense_i && locked && failed_auth_counter == AUTH_FAIL_ZERO)
      |=> (state == NTS_SENSE) && !locked;
  endproperty
  a_release: assert property (p_release) else $error("lock not released"); // [RULE15]

endmodule

`default_nettype wire

// ==== hw/nts_pkg.sv ====
// constants and types for the nfc-a tag state machine
package nts_pkg;

  // ****************************************
  // command codes, decoded upstream
  // ****************************************
  typedef enum logic [3:0] {
    NTS_CMD_SENS   = 4'h1,
    NTS_CMD_ALL    = 4'h2,
    NTS_CMD_SDD    = 4'h3,
    NTS_CMD_SEL    = 4'h4,
    NTS_CMD_SLP    = 4'h5,
    NTS_CMD_READ   = 4'h6,
    NTS_CMD_WRITE  = 4'h7,
    NTS_CMD_SECSEL = 4'h8,
    NTS_CMD_OTHER  = 4'hF
  } nts_cmd_t;

  // ****************************************
  // protocol states
  // ****************************************
  typedef enum logic [2:0] {
    NTS_SENSE  = 3'b000,
    NTS_SLEEP  = 3'b001,
    NTS_RES1   = 3'b010,
    NTS_RES2   = 3'b011,
    NTS_SELECT = 3'b100,
    NTS_AUTH   = 3'b101
  } nts_state_t;

  // ****************************************
  // response kinds
  // ****************************************
  typedef enum logic [2:0] {
    NTS_RSP_NONE  = 3'b000,
    NTS_RSP_SENS  = 3'b001,
    NTS_RSP_UID   = 3'b010,
    NTS_RSP_SAK   = 3'b011,
    NTS_RSP_ACK   = 3'b100,
    NTS_RSP_DATA  = 3'b101,
    NTS_RSP_NAK   = 3'b110
  } nts_rsp_t;

  // ****************************************
  // kill configuration and uid constants
  // ****************************************
  localparam logic [1:0] KILL_NONE = 2'h0;
  localparam logic [1:0] KILL_HOST = 2'h1;
  localparam logic [1:0] KILL_RF   = 2'h2;
  localparam logic [7:0] UID_BYTE2 = 8'h02;
  localparam logic [7:0] CASCADE_TAG = 8'h88;  // marks a longer uid at cascade level one
  localparam logic [2:0] AUTH_FAIL_LIMIT = 3'h7;
  localparam logic [2:0] AUTH_FAIL_ZERO  = 3'h0;
  localparam int         ADDR_W = 8;

endpackage

// ==== verification/nts_reader_model.sv ====
// reader-side model that issues decoded rf frames to the tag
`timescale 1ns/1ns
`default_nettype none

module nts_reader_model
  import nts_pkg::*;
(
  // clock
  input  wire logic              clk_i,
  // frames towards the tag
  output var  logic              cmd_valid_o,
  output var  logic [3:0]        cmd_code_o,
  output var  logic [ADDR_W-1:0] cmd_addr_o,
  output var  logic              cmd_sel_ok_o,
  output var  logic              cmd_pwd_ok_o,
  // tag answer
  input  wire logic              rsp_valid_i,
  input  wire logic [2:0]        rsp_kind_i
);
  // ****************************************
  // idle lines
  // ****************************************
  initial begin
    cmd_valid_o  = 1'b0;
    cmd_code_o   = 4'h0;
    cmd_addr_o   = 8'h00;
    cmd_sel_ok_o = 1'b0;
    cmd_pwd_ok_o = 1'b0;
  end

  // ****************************************
  // one frame, answer taken at the falling edge after the tag samples it
  // ****************************************
  // a password write carries pwd_ok when the word matches
  task automatic send(input logic [3:0] code, input logic [7:0] addr, input logic sel,
                      input logic pwd, output logic got_v, output logic [2:0] got_k);
    @(posedge clk_i);
    cmd_valid_o  <= 1'b1;
    cmd_code_o   <= code;
    cmd_addr_o   <= addr;
    cmd_sel_ok_o <= sel;
    cmd_pwd_ok_o <= pwd;
    @(posedge clk_i);
    // released lines show the inverse, never a stale copy
    cmd_valid_o  <= 1'b0;
    cmd_code_o   <= ~code;
    cmd_addr_o   <= ~addr;
    cmd_sel_ok_o <= ~sel;
    cmd_pwd_ok_o <= ~pwd;
    @(negedge clk_i);
    got_v = rsp_valid_i;
    got_k = rsp_kind_i;
  endtask
endmodule

`default_nettype wire

// ==== verification/nts_tag_fsm_tb.sv ====
// self-checking testbench for the nfc-a tag state machine
`timescale 1ns/1ns
`default_nettype none

`define CHK(nm, e, g) begin total_checks++; if ((e) !== (g)) begin n_fail++; \
  $display("[FAIL] %s exp %0h got %0h", nm, e, g); end end

module nts_tag_fsm_tb
  import nts_pkg::*;
;
  // ****************************************
  // signals
  // ****************************************
  logic clk_i = 1'b0;
  logic rst_b_i = 1'b0;
  logic cv, sok, pok, tun = 1'b0;
  logic [3:0] cc;
  logic [7:0] ca;
  logic kwe = 1'b0, clr = 1'b0, gos = 1'b0, rkwe = 1'b0;
  logic [1:0] kill = KILL_NONE;
  logic [7:0] plim = 8'h20;
  logic [31:0] uidw = 32'hC3B2A190;
  logic rv, mr, mw, ten, lk;
  logic [2:0] rk, st, fc;
  logic [31:0] ruid, luid;
  logic [7:0] maddr, laddr;
  logic lrd, lwr;
  int n_fail = 0;
  int total_checks = 0;

  always #50 clk_i = ~clk_i;

  nts_tag_fsm dut (.clk_i(clk_i), .rst_b_i(rst_b_i), .cmd_valid_i(cv), .cmd_code_i(cc),
    .cmd_addr_i(ca), .cmd_sel_ok_i(sok), .cmd_pwd_ok_i(pok), .cmd_tunnel_i(tun),
    .mcu_kill_we_i(kwe), .mcu_kill_i(kill), .mcu_cnt_clr_i(clr), .mcu_goto_sense_i(gos),
    .rf_kill_we_i(rkwe), .prot_limit_i(plim), .uid_word_i(uidw), .rsp_valid_o(rv),
    .rsp_kind_o(rk), .rsp_uid_o(ruid), .mem_rd_o(mr), .mem_wr_o(mw), .mem_addr_o(maddr),
    .tunnel_en_o(ten), .state_o(st), .locked_o(lk), .fail_cnt_o(fc));

  nts_reader_model rdr (.clk_i(clk_i), .cmd_valid_o(cv), .cmd_code_o(cc), .cmd_addr_o(ca),
    .cmd_sel_ok_o(sok), .cmd_pwd_ok_o(pok), .rsp_valid_i(rv), .rsp_kind_i(rk));

  // ****************************************
  // shared tasks
  // ****************************************
  // frame, answer kind (7 = any) and state one cycle on (7 = any)
  task automatic cmd(input logic [3:0] c, input logic [7:0] a, input logic s, input logic p,
                     input logic [2:0] ek, input logic [2:0] es);
    logic v;
    logic [2:0] k;
    rdr.send(c, a, s, p, v, k);
    luid = ruid;
    lrd = mr;
    lwr = mw;
    laddr = maddr;
    if (ek != 3'h7) begin
      `CHK("rsp_valid", ek != NTS_RSP_NONE, v)
      if (ek != NTS_RSP_NONE) `CHK("rsp_kind", ek, k)
    end
    @(negedge clk_i);
    if (es != 3'h7) `CHK("state", es, st)
  endtask

  // one-cycle microcontroller strobe, then let the state settle
  task automatic mcu(input int which);
    @(posedge clk_i);
    if (which == 0) kwe <= 1'b1;
    if (which == 1) clr <= 1'b1;
    if (which == 2) gos <= 1'b1;
    if (which == 3) rkwe <= 1'b1;
    @(posedge clk_i);
    kwe <= 1'b0;
    clr <= 1'b0;
    gos <= 1'b0;
    rkwe <= 1'b0;
    repeat (3) @(negedge clk_i);
  endtask

  // full activation from a waiting state
  task automatic activate(input logic [3:0] wake);
    cmd(wake, 8'h00, 1'b0, 1'b0, NTS_RSP_SENS, NTS_RES1);
    cmd(NTS_CMD_SDD, 8'h00, 1'b0, 1'b0, NTS_RSP_UID, NTS_RES1);
    `CHK("uid level1", {UID_BYTE2, 8'h5A, 8'hA5, CASCADE_TAG}, luid)
    cmd(NTS_CMD_SEL, 8'h00, 1'b1, 1'b0, NTS_RSP_SAK, NTS_RES2);
    cmd(NTS_CMD_SDD, 8'h00, 1'b0, 1'b0, NTS_RSP_UID, NTS_RES2);
    `CHK("uid level2", uidw, luid)
    cmd(NTS_CMD_SEL, 8'h00, 1'b1, 1'b0, NTS_RSP_SAK, NTS_SELECT);
  endtask

  task automatic close_out();
    $display("checks %0d mismatches %0d", total_checks, n_fail);
    if (n_fail == 0 && total_checks > 0)
      $display("DONE - PASS");
    else
      $display("DONE - FAIL");
    $finish;
  endtask

  // ****************************************
  // scenarios
  // ****************************************
  task automatic t_sense();
    `CHK("reset state", NTS_SENSE, st)
    cmd(NTS_CMD_READ, 8'h10, 1'b0, 1'b0, 3'h7, NTS_SENSE);
    `CHK("no read outside selected", 1'b0, lrd)
    cmd(NTS_CMD_OTHER, 8'h00, 1'b0, 1'b0, 3'h7, NTS_SENSE);
    cmd(NTS_CMD_SLP, 8'h00, 1'b0, 1'b0, 3'h7, NTS_SENSE);
    $display("test sense done");
  endtask

  task automatic t_mem();
    activate(NTS_CMD_SENS);
    cmd(NTS_CMD_READ, 8'h10, 1'b0, 1'b0, NTS_RSP_DATA, NTS_SELECT);
    `CHK("read strobe", 1'b1, lrd)
    `CHK("read address", 8'h10, laddr)
    cmd(NTS_CMD_WRITE, 8'h11, 1'b0, 1'b0, NTS_RSP_ACK, NTS_SELECT);
    `CHK("write strobe", 1'b1, lwr)
    cmd(NTS_CMD_READ, 8'h40, 1'b0, 1'b0, NTS_RSP_NAK, 3'h7);
    `CHK("no read beyond top", 1'b0, lrd)
    cmd(NTS_CMD_OTHER, 8'h00, 1'b0, 1'b0, 3'h7, NTS_SENSE);
    activate(NTS_CMD_ALL);
    cmd(NTS_CMD_WRITE, 8'h00, 1'b0, 1'b0, NTS_RSP_NAK, 3'h7);
    `CHK("no uid write", 1'b0, lwr)
    cmd(NTS_CMD_OTHER, 8'h00, 1'b0, 1'b0, 3'h7, NTS_SENSE);
    activate(NTS_CMD_ALL);
    cmd(NTS_CMD_READ, 8'h30, 1'b0, 1'b0, NTS_RSP_NAK, 3'h7);
    `CHK("no protected read", 1'b0, lrd)
    cmd(NTS_CMD_OTHER, 8'h00, 1'b0, 1'b0, 3'h7, NTS_SENSE);
    activate(NTS_CMD_ALL);
    cmd(NTS_CMD_WRITE, 8'h3E, 1'b0, 1'b1, NTS_RSP_ACK, NTS_AUTH);
    `CHK("no password mem write", 1'b0, lwr)
    cmd(NTS_CMD_READ, 8'h30, 1'b0, 1'b0, NTS_RSP_DATA, NTS_AUTH);
    `CHK("protected read", 1'b1, lrd)
    cmd(NTS_CMD_SECSEL, 8'h00, 1'b0, 1'b0, NTS_RSP_NAK, NTS_SENSE);
    $display("test memory done");
  endtask

  task automatic t_sleep();
    activate(NTS_CMD_SENS);
    cmd(NTS_CMD_SLP, 8'h00, 1'b0, 1'b0, 3'h7, NTS_SLEEP);
    cmd(NTS_CMD_SENS, 8'h00, 1'b0, 1'b0, 3'h7, NTS_SLEEP);
    activate(NTS_CMD_ALL);
    cmd(NTS_CMD_OTHER, 8'h00, 1'b0, 1'b0, 3'h7, NTS_SLEEP);
    activate(NTS_CMD_ALL);
    cmd(NTS_CMD_SECSEL, 8'h00, 1'b0, 1'b0, NTS_RSP_NAK, NTS_SLEEP);
    $display("test sleep done");
  endtask

  task automatic t_lock();
    activate(NTS_CMD_ALL);
    for (int i = 1; i <= 7; i++) begin
      cmd(NTS_CMD_WRITE, 8'h3E, 1'b0, 1'b0, NTS_RSP_NAK, NTS_SELECT);
      `CHK("fail count", i[2:0], fc)
    end
    repeat (2) @(negedge clk_i);
    `CHK("locked", 1'b1, lk)
    cmd(NTS_CMD_READ, 8'h30, 1'b0, 1'b0, NTS_RSP_NAK, 3'h7);
    cmd(NTS_CMD_OTHER, 8'h00, 1'b0, 1'b0, 3'h7, NTS_SLEEP);
    activate(NTS_CMD_ALL);
    cmd(NTS_CMD_READ, 8'h10, 1'b0, 1'b0, NTS_RSP_DATA, 3'h7);
    mcu(2);
    `CHK("still locked", 1'b1, lk)
    mcu(1);
    mcu(2);
    `CHK("unlocked", 1'b0, lk)
    `CHK("count cleared", AUTH_FAIL_ZERO, fc)
    `CHK("back to sense", NTS_SENSE, st)
    $display("test lock done");
  endtask

  task automatic t_kill();
    @(posedge clk_i);
    tun <= 1'b1;
    activate(NTS_CMD_ALL);
    `CHK("tunnel allowed", 1'b1, ten)
    mcu(2);
    @(posedge clk_i);
    kill <= KILL_RF;
    mcu(3);
    cmd(NTS_CMD_SENS, 8'h00, 1'b0, 1'b0, NTS_RSP_SENS, NTS_RES1);
    mcu(0);
    cmd(NTS_CMD_ALL, 8'h00, 1'b0, 1'b0, NTS_RSP_NONE, 3'h7);
    cmd(NTS_CMD_SDD, 8'h00, 1'b0, 1'b0, NTS_RSP_NONE, 3'h7);
    @(posedge clk_i);
    kill <= KILL_HOST;
    mcu(0);
    mcu(2);
    activate(NTS_CMD_ALL);
    cmd(NTS_CMD_READ, 8'h10, 1'b0, 1'b0, NTS_RSP_DATA, NTS_SELECT);
    `CHK("tunnel refused", 1'b0, ten)
    $display("test kill done");
  endtask

  // ****************************************
  // main sequence and watchdog
  // ****************************************
  initial begin
    repeat (10) @(posedge clk_i);
    rst_b_i <= 1'b1;
    @(negedge clk_i);
    t_sense();
    t_mem();
    t_sleep();
    t_lock();
    t_kill();
    close_out();
  end

  initial begin
    #(6000 * 100);
    n_fail++;
    close_out();
  end
endmodule

`default_nettype wire
